/* File: hw/ewed_top.sv */
// The APB register port was decided locally.
`timescale 1ns/1ps
module ewed_top (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources from pins
	input wire logic general_pin_4,
	input wire logic general_pin_5,
	input wire logic bus_activity,
	// Wake request and flags
	output logic [2:0] event_flags,
	output logic wake_req
);
	// ==========================================================
	// Registers
	logic [7:0] pin_cfg_r;
	logic [3:0] bus_cfg_r;
	logic [2:0] flag_r, flag_nxt;
	logic [2:0] hit;
	logic wr, rd_sel_ok;
	logic [2:0] clr;
	ewed_pkg::ewed_src_cfg_t cfg4, cfg5, cfgb;

	assign wr = psel & penable & pwrite;
	assign rd_sel_ok = paddr == ewed_pkg::PIN_CFG_OFS
		|| paddr == ewed_pkg::BUS_CFG_OFS
		|| paddr == ewed_pkg::CLR_OFS
		|| paddr == ewed_pkg::FLAG_OFS;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_sel_ok;

	// Config write; bus config keeps only its four live bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cfg_r <= ewed_pkg::PIN_CFG_RST;
			bus_cfg_r <= ewed_pkg::BUS_CFG_RST;
		end else if (ce && wr) begin
			if (paddr == ewed_pkg::PIN_CFG_OFS)
				pin_cfg_r <= pwdata[7:0];
			if (paddr == ewed_pkg::BUS_CFG_OFS)
				bus_cfg_r <= pwdata[3:0];
		end
	end

	// Source settings
	assign cfg4 = '{pin_cfg_r[ewed_pkg::P4_EN_BIT],
		pin_cfg_r[ewed_pkg::P4_MODE_LSB +: 3]};
	assign cfg5 = '{pin_cfg_r[ewed_pkg::P5_EN_BIT],
		pin_cfg_r[ewed_pkg::P5_MODE_LSB +: 3]};
	assign cfgb = '{bus_cfg_r[ewed_pkg::BUS_EN_BIT],
		bus_cfg_r[ewed_pkg::BUS_MODE_LSB +: 3]};

	ewed_detect u_p4 (.pclk(pclk), .presetn(presetn), .ce(ce),
		.src_async(general_pin_4), .cfg(cfg4), .hit(hit[0]));
	ewed_detect u_p5 (.pclk(pclk), .presetn(presetn), .ce(ce),
		.src_async(general_pin_5), .cfg(cfg5), .hit(hit[1]));
	ewed_detect u_bus (.pclk(pclk), .presetn(presetn), .ce(ce),
		.src_async(bus_activity), .cfg(cfgb), .hit(hit[2]));

	// Clear pulses exist only in the write cycle, so the bit self-clears
	assign clr = (wr && paddr == ewed_pkg::CLR_OFS) ?
		{pwdata[ewed_pkg::CLR_BUS_BIT], pwdata[ewed_pkg::CLR_P5_BIT],
		pwdata[ewed_pkg::CLR_P4_BIT]} : 3'h0;
	// A hit in the clear cycle wins, so no event is lost
	assign flag_nxt = (flag_r & ~clr) | hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_r <= 3'h0;
		else if (ce)
			flag_r <= flag_nxt;
	end
	assign event_flags = flag_r;
	assign wake_req = |flag_r;

	// Read mux; clear register always reads zero
	always_comb begin
		prdata = 32'h0;
		case (paddr)
		ewed_pkg::PIN_CFG_OFS: prdata = {24'h0, pin_cfg_r};
		ewed_pkg::BUS_CFG_OFS: prdata = {28'h0, bus_cfg_r};
		ewed_pkg::FLAG_OFS: prdata = {23'h0, flag_r[2], 2'h0,
			flag_r[1], flag_r[0], 4'h0};
		default: prdata = 32'h0;
		endcase
	end

	// ==========================================================
	// Checks
	property p_flag_set;
		@(posedge pclk) disable iff (!presetn) ce && hit[1] |=> flag_r[1];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");
	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		ce && clr[0] && !hit[0] |=> !flag_r[0];
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");
	property p_dis;
		@(posedge pclk) disable iff (!presetn) !pin_cfg_r[7] |-> !hit[1];
	endproperty
	a_dis: assert property (p_dis) else $error("pin5 off hit");
	property p_dis4;
		@(posedge pclk) disable iff (!presetn) !pin_cfg_r[3] |-> !hit[0];
	endproperty
	a_dis4: assert property (p_dis4) else $error("pin4 off hit");
	property p_disb;
		@(posedge pclk) disable iff (!presetn) !bus_cfg_r[3] |-> !hit[2];
	endproperty
	a_disb: assert property (p_disb) else $error("bus off hit");
	property p_rsvd;
		@(posedge pclk) disable iff (!presetn)
		paddr == ewed_pkg::BUS_CFG_OFS |-> prdata[31:4] == 28'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_lvl;
		@(posedge pclk) disable iff (!presetn)
		ce && bus_cfg_r == 4'hB && $stable(bus_activity) && bus_activity
		##1 ce && bus_activity ##1 ce |=> bus_cfg_r != 4'hB || hit[2];
	endproperty
	a_lvl: assert property (p_lvl) else $error("level miss");

	// ==========================================================
	// Mode decoding, checked against the synchroniser taps
	// Alias code 7 on pin 5 must behave as high level
	property p_mode5;
		@(posedge pclk) disable iff (!presetn)
		pin_cfg_r[7:4] == 4'hF |-> hit[1] == u_p5.s2_r;
	endproperty
	a_mode5: assert property (p_mode5) else $error("pin5 alias");
	// Plain rise on pin 5 fires only on a low-to-high step
	property p_rise5;
		@(posedge pclk) disable iff (!presetn)
		pin_cfg_r[7:4] == 4'h8 |-> hit[1] == (u_p5.s2_r & !u_p5.prev_r);
	endproperty
	a_rise5: assert property (p_rise5) else $error("pin5 rise");
	// Alias code 6 on pin 4 must behave as either edge
	property p_alias4;
		@(posedge pclk) disable iff (!presetn)
		pin_cfg_r[3:0] == 4'hE |-> hit[0] == (u_p4.s2_r ^ u_p4.prev_r);
	endproperty
	a_alias4: assert property (p_alias4) else $error("pin4 both");
	// Alias code 5 on pin 4 must behave as falling edge
	property p_alias4f;
		@(posedge pclk) disable iff (!presetn)
		pin_cfg_r[3:0] == 4'hD |-> hit[0] == (u_p4.prev_r & !u_p4.s2_r);
	endproperty
	a_alias4f: assert property (p_alias4f) else $error("pin4 fall");
	// Low level on the bus line hits for as long as it lasts
	property p_low_bus;
		@(posedge pclk) disable iff (!presetn)
		bus_cfg_r == 4'hC |-> hit[2] == !u_bus.s2_r;
	endproperty
	a_low_bus: assert property (p_low_bus) else $error("bus low");

	// ==========================================================
	// Flag life cycle
	// A set flag stays until software clears it
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		ce && flag_r[1] && !clr[1] |=> flag_r[1];
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped");
	// No flag appears without a hit behind it
	property p_nospur;
		@(posedge pclk) disable iff (!presetn)
		ce && !flag_r[2] && !hit[2] |=> !flag_r[2];
	endproperty
	a_nospur: assert property (p_nospur) else $error("spurious flag");
	// Clock enable low freezes flags and settings alike
	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(flag_r) && $stable(pin_cfg_r) && $stable(bus_cfg_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved");
	// Only the four live bits of a bus config write are kept
	property p_cfg_wr;
		@(posedge pclk) disable iff (!presetn)
		ce && wr && paddr == ewed_pkg::BUS_CFG_OFS
		|=> bus_cfg_r == $past(pwdata[3:0]);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("cfg not kept");
	// Any enabled hit raises the wake request on the next edge
	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		ce && |hit |=> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	// ==========================================================
	// Synchroniser depth: pin reaches logic only after two flops
	property p_sync1;
		@(posedge pclk) disable iff (!presetn)
		$past(ce) && !$past(general_pin_5) |-> !u_p5.s1_r;
	endproperty
	a_sync1: assert property (p_sync1) else $error("first flop");
	// The second flop copies the first one cycle later
	property p_sync2;
		@(posedge pclk) disable iff (!presetn)
		$past(ce) |-> u_p5.s2_r == $past(u_p5.s1_r);
	endproperty
	a_sync2: assert property (p_sync2) else $error("second flop");

	// Main scenarios worth seeing at least once
	c_flag: cover property (@(posedge pclk) flag_r[1]);
	c_bus: cover property (@(posedge pclk) flag_r[2]);
	c_clr: cover property (@(posedge pclk) |clr);
	c_reraise: cover property (@(posedge pclk) clr[2] ##1 flag_r[2]);
endmodule

/* File: shared/ewed_pkg.sv */
// Notes on behaviour
// - Pin-5 enable (bit 7) turns on pin-5 detection and wake; 0 disables it.
// - Pin-5 mode (bits 6:4): rise, fall, both, high, low; 5..7 act as 1..3.
// - Pin-4 enable (bit 3) turns on pin-4 detection and wake; 0 disables it.
// - Pin-4 mode (bits 2:0) uses the same encoding and aliases as pin 5.
// - Bus config bit 3 enables bus-activity wake detection; 0 disables it.
// - Bus mode (bits 2:0) uses the same five modes and aliases.
// - Bus wake config resets to zero; bits 31:4 are read-only zero.
// - A hit latches a flag; a 1 written to its self-clearing clear bit clears it.
package ewed_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] PIN_CFG_OFS = 12'hA24;
	localparam logic [11:0] BUS_CFG_OFS = 12'hA28;
	localparam logic [11:0] CLR_OFS = 12'hA30;
	localparam logic [11:0] FLAG_OFS = 12'hA34;
	// ==========================================================
	// Field positions
	localparam int P5_EN_BIT = 7;
	localparam int P5_MODE_LSB = 4;
	localparam int P4_EN_BIT = 3;
	localparam int P4_MODE_LSB = 0;
	localparam int BUS_EN_BIT = 3;
	localparam int BUS_MODE_LSB = 0;
	localparam int CLR_P4_BIT = 4;
	localparam int CLR_P5_BIT = 5;
	localparam int CLR_BUS_BIT = 8;
	// ==========================================================
	// Reset values
	localparam logic [7:0] PIN_CFG_RST = 8'h00;
	localparam logic [3:0] BUS_CFG_RST = 4'h0;
	// ==========================================================
	// Detection modes
	typedef enum logic [2:0] {
		EWED_RISE = 3'h0, EWED_FALL = 3'h1, EWED_BOTH = 3'h2,
		EWED_HIGH = 3'h3, EWED_LOW = 3'h4
	} ewed_mode_t;
	// One source setting travels as a struct
	typedef struct packed {
		logic en;
		logic [2:0] mode;
	} ewed_src_cfg_t;
endpackage

/* File: hw/ewed_detect.sv */
`timescale 1ns/1ps
module ewed_detect (
	// Clocking
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Source
	input wire logic src_async,
	input wire ewed_pkg::ewed_src_cfg_t cfg,
	// Result
	output logic hit
);
	logic s1_r, s2_r, prev_r;
	logic [2:0] m;
	logic rise, fall;

	// Two-flop synchroniser, then a history flop for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (ce) begin
			s1_r <= src_async;
			s2_r <= s1_r;
			prev_r <= s2_r;
		end
	end

	// Codes 5..7 fold onto 1..3 by subtracting four
	assign m = (cfg.mode > 3'h4) ? cfg.mode - 3'h4 : cfg.mode;
	assign rise = s2_r & ~prev_r;
	assign fall = ~s2_r & prev_r;
	// Level modes keep hitting while the level lasts
	assign hit = cfg.en & (
		(m == ewed_pkg::EWED_RISE) ? rise :
		(m == ewed_pkg::EWED_FALL) ? fall :
		(m == ewed_pkg::EWED_BOTH) ? (rise | fall) :
		(m == ewed_pkg::EWED_HIGH) ? s2_r : ~s2_r);
endmodule

/* File: tb/ewed_far_side.sv */
`timescale 1ns/1ps
module ewed_far_side (
	// Clock
	input wire logic pclk,
	// Levels: [0] pin 4, [1] pin 5, [2] bus activity
	output logic [2:0] lvl
);
	// ==========================================
	// Idle lines sit high, as with pull-ups
	initial lvl = 3'b111;
	// Changes land just after an edge; no glitches are modelled
	task automatic drive(input int s, input logic v);
		@(posedge pclk);
		lvl[s] <= v;
	endtask
endmodule

/* File: tb/external_wake_event_detect_test.sv */
`timescale 1ns/1ps
module external_wake_event_detect_test;
	// ==========================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] lvl;
	logic [2:0] event_flags;
	logic wake_req;
	logic [31:0] rd;
	logic err;
	int bad_count = 0;
	int n_compared = 0;
	always #12.5 pclk = ~pclk;
	ewed_far_side far (.pclk(pclk), .lvl(lvl));
	ewed_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .general_pin_4(lvl[0]),
		.general_pin_5(lvl[1]), .bus_activity(lvl[2]),
		.event_flags(event_flags), .wake_req(wake_req));
	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Six cycles covers the two-flop synchroniser plus the flag
	task automatic settle(input logic [2:0] e, input logic clr);
		if (clr) apb(1'b1, ewed_pkg::CLR_OFS, 32'h0000_0130);
		repeat (6) @(posedge pclk);
		chk({29'h0, event_flags}, {29'h0, e});
		chk({31'h0, wake_req}, {31'h0, |e});
	endtask
	// One code on one source; the others stay disabled
	task automatic run(input int s, input logic [2:0] m);
		logic [2:0] e;
		logic [2:0] b;
		e = (m > 3'h4) ? m - 3'h4 : m;
		b = 3'b001 << s;
		apb(1'b1, ewed_pkg::PIN_CFG_OFS, s == 0 ? {28'h0, 1'b1, m} :
			s == 1 ? {24'h0, 1'b1, m, 4'h0} : 32'h0);
		apb(1'b1, ewed_pkg::BUS_CFG_OFS, s == 2 ? {28'h0, 1'b1, m} : 32'h0);
		settle(b & {3{e == ewed_pkg::EWED_HIGH}}, 1'b1);
		far.drive(s, 1'b0);
		settle(b & {3{e != ewed_pkg::EWED_RISE}}, 1'b0);
		settle(b & {3{e == ewed_pkg::EWED_LOW}}, 1'b1);
		far.drive(s, 1'b1);
		settle(b & {3{e != ewed_pkg::EWED_FALL}}, 1'b0);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ewed_pkg::BUS_CFG_OFS, 32'h0);
		chk(rd, 32'h0000_0000);
		chk({29'h0, event_flags}, 32'h0);
		apb(1'b1, ewed_pkg::BUS_CFG_OFS, 32'hFFFF_FFFF);
		apb(1'b0, ewed_pkg::BUS_CFG_OFS, 32'h0);
		chk(rd, 32'h0000_000F);
		ce <= 1'b0;
		apb(1'b1, ewed_pkg::BUS_CFG_OFS, 32'h0);
		ce <= 1'b1;
		apb(1'b0, ewed_pkg::BUS_CFG_OFS, 32'h0);
		chk(rd, 32'h0000_000F);
		apb(1'b0, 12'h000, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int s = 0; s < 3; s++) begin
			for (int m = 0; m < 8; m++) begin
				run(s, m[2:0]);
			end
		end
		apb(1'b0, ewed_pkg::FLAG_OFS, 32'h0);
		chk(rd, 32'h0000_0100);
		apb(1'b0, ewed_pkg::CLR_OFS, 32'h0);
		chk(rd, 32'h0000_0000);
		close_out();
	end
	// Watchdog, well beyond the expected run time
	initial begin
		#200us;
		bad_count++;
		close_out();
	end
endmodule
